// ---- rtl/pif_pkg.sv ----
// pif_pkg: register map, bit positions, reset values and bus states of the
// peripheral interrupt flag and enable block; shared by design and bench.
// Contract
// (RULE_01) Oscillator failure with switch to internal oscillator sets flag bit 7; software clears.
// (RULE_02) Comparator two or one input change sets bit 6 or 5 until cleared.
// (RULE_03) A USB interrupt request sets bit 4 until software clears it.
// (RULE_04) Collision in sync serial one or two sets its flag; software clears.
// (RULE_05) Low core voltage sets bit 2; zero while supply is high; software clears.
// (RULE_06) Timer three overflow sets bit 1 until software clears it.
// (RULE_07) In capture mode a capture sets that capture/compare unit's flag.
// (RULE_08) In compare mode a match sets the same unit flag until cleared.
// (RULE_09) A unit in pulse-width mode never sets its flag.
// (RULE_10) Sync serial two completion sets bit 7 of flags three; software clears.
// (RULE_11) Serial two receive flag is read-only, high while buffer full, cleared by read.
// (RULE_12) Serial two transmit flag high while buffer empty, cleared when buffer written.
// (RULE_13) Timer four count equal to period sets bit 3 until cleared.
// (RULE_14) Without priorities no peripheral interrupt passes unless global enable is set.
// (RULE_15) First enable register gates eight first-register sources, one enables.
// (RULE_16) Flags set whatever the enable and global enable bits hold.
// (RULE_17) With priorities on, global enable gates low-priority peripheral interrupts.
// (RULE_18) Software clears flags before enabling and after servicing an interrupt.
// (RULE_19) A set flag with its enable set raises the request, under global gating.
package pif_pkg;
  localparam logic [7:0] ADDR_FLAGS_TWO     = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_THREE   = 8'h04;
  localparam logic [7:0] ADDR_ENABLES_ONE   = 8'h08;
  localparam logic [7:0] ADDR_ENABLES_TWO   = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES_THREE = 8'h10;
  localparam logic [7:0] ADDR_CONTROL       = 8'h14;
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [7:0] FLAGS_THREE_HW_MASK = 8'h30;
  localparam int BIT_OSC_FAIL   = 7;
  localparam int BIT_CMP_TWO    = 6;
  localparam int BIT_CMP_ONE    = 5;
  localparam int BIT_USB        = 4;
  localparam int BIT_COLL_ONE   = 3;
  localparam int BIT_LOW_VOLT   = 2;
  localparam int BIT_TMR3_OVF   = 1;
  localparam int BIT_CCP_TWO    = 0;
  localparam int BIT_SSP_TWO    = 7;
  localparam int BIT_COLL_TWO   = 6;
  localparam int BIT_RX_TWO     = 5;
  localparam int BIT_TX_TWO     = 4;
  localparam int BIT_TMR4_MATCH = 3;
  localparam int BIT_CCP_FIVE   = 2;
  localparam int BIT_CCP_FOUR   = 1;
  localparam int BIT_CCP_THREE  = 0;
  localparam int CTRL_GLOBAL    = 0;
  localparam int CTRL_PRIO      = 1;
  localparam logic [1:0] HTRANS_NONSEQ_BIT1 = 2'b10;
  typedef enum logic [1:0] {
    PIF_BUS_IDLE = 2'b01,
    PIF_BUS_WAIT = 2'b10
  } pif_bus_e;
endpackage : pif_pkg

// ---- rtl/pif_top.sv ----
// pif_top: peripheral interrupt flags two and three, enables one to three,
// global gating and an AHB-Lite slave with one wait state per transfer.
// assumes all event inputs are synchronous one-cycle pulses on hclk.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pif_top
  import pif_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_fail_evt,
  input  wire logic        cmp_two_evt,
  input  wire logic        cmp_one_evt,
  input  wire logic        usb_req_evt,
  input  wire logic        coll_one_evt,
  input  wire logic        coll_two_evt,
  input  wire logic        low_volt_evt,
  input  wire logic        tmr3_ovf_evt,
  input  wire logic        tmr4_match_evt,
  input  wire logic        ssp_two_done_evt,
  input  wire logic [3:0]  ccp_capture_evt,
  input  wire logic [3:0]  ccp_match_evt,
  input  wire logic [3:0]  ccp_pwm_mode,
  input  wire logic        rx_two_full,
  input  wire logic        rx_two_buf_read,
  input  wire logic        tx_two_empty,
  input  wire logic        tx_two_buf_write,
  input  wire logic [7:0]  flags_one_in,
  input  wire logic [23:0] prio_high_in,
  output logic             periph_irq,
  output logic             irq_high,
  output logic             irq_low
);

  pif_bus_e    bus_state_ff, nxt_bus_state;
  logic [7:0]  addr_ff, nxt_addr;
  logic        write_ff, nxt_write;
  logic        hreadyout_ff, nxt_hreadyout;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [7:0]  flags_two_ff, nxt_flags_two;
  logic [7:0]  flags_three_ff, nxt_flags_three;
  logic [7:0]  enables_one_ff, nxt_enables_one;
  logic [7:0]  enables_two_ff, nxt_enables_two;
  logic [7:0]  enables_three_ff, nxt_enables_three;
  logic [1:0]  control_ff, nxt_control;
  logic        periph_irq_ff, nxt_periph_irq;
  logic        irq_high_ff, nxt_irq_high;
  logic        irq_low_ff, nxt_irq_low;
  logic        accept;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [3:0]  ccp_set;
  logic [7:0]  set_two;
  logic [7:0]  set_three;
  logic [23:0] pend;
  logic        any_high;
  logic        any_low;

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = 1'b0 & hsize[0];
  assign periph_irq = periph_irq_ff;
  assign irq_high   = irq_high_ff;
  assign irq_low    = irq_low_ff;

  // bus: address phase taken, then one wait cycle in which writes land
  always_comb begin
    accept        = hsel && ((htrans & HTRANS_NONSEQ_BIT1) != 2'b00) && hready;
    nxt_bus_state = accept ? PIF_BUS_WAIT : PIF_BUS_IDLE;
    nxt_addr      = accept ? haddr[7:0] : addr_ff;
    nxt_write     = accept ? hwrite : write_ff;
    nxt_hreadyout = !accept;
    wr_en         = (bus_state_ff == PIF_BUS_WAIT) && write_ff;
    wbyte         = hwdata[7:0];
    case (addr_ff)
      ADDR_FLAGS_TWO:     rbyte = flags_two_ff;
      ADDR_FLAGS_THREE:   rbyte = flags_three_ff;
      ADDR_ENABLES_ONE:   rbyte = enables_one_ff;
      ADDR_ENABLES_TWO:   rbyte = enables_two_ff;
      ADDR_ENABLES_THREE: rbyte = enables_three_ff;
      ADDR_CONTROL:       rbyte = {6'h00, control_ff};
      default:            rbyte = RESET_BYTE;
    endcase
    case (bus_state_ff)
      PIF_BUS_WAIT: nxt_hrdata = write_ff ? hrdata_ff : {24'h000000, rbyte};
      PIF_BUS_IDLE: nxt_hrdata = hrdata_ff;
      default:      nxt_hrdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_ff <= PIF_BUS_IDLE;
      addr_ff      <= 8'h00;
      write_ff     <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h00000000;
    end else begin
      bus_state_ff <= nxt_bus_state;
      addr_ff      <= nxt_addr;
      write_ff     <= nxt_write;
      hreadyout_ff <= nxt_hreadyout;
      hrdata_ff    <= nxt_hrdata;
    end
  end

  // flags: events set regardless of enables, set wins over write-one clear
  always_comb begin
    ccp_set = (ccp_capture_evt | ccp_match_evt) & ~ccp_pwm_mode; // [RULE_07] [RULE_08] [RULE_09]
    set_two = 8'h00;
    set_two[BIT_OSC_FAIL] = osc_fail_evt;   // [RULE_01] [RULE_16]
    set_two[BIT_CMP_TWO]  = cmp_two_evt;    // [RULE_02]
    set_two[BIT_CMP_ONE]  = cmp_one_evt;    // [RULE_02]
    set_two[BIT_USB]      = usb_req_evt;    // [RULE_03]
    set_two[BIT_COLL_ONE] = coll_one_evt;   // [RULE_04]
    set_two[BIT_LOW_VOLT] = low_volt_evt;   // [RULE_05]
    set_two[BIT_TMR3_OVF] = tmr3_ovf_evt;   // [RULE_06]
    set_two[BIT_CCP_TWO]  = ccp_set[0];     // [RULE_07]
    set_three = 8'h00;
    set_three[BIT_SSP_TWO]    = ssp_two_done_evt; // [RULE_10]
    set_three[BIT_COLL_TWO]   = coll_two_evt;     // [RULE_04]
    set_three[BIT_TMR4_MATCH] = tmr4_match_evt;   // [RULE_13]
    set_three[BIT_CCP_THREE]  = ccp_set[1];       // [RULE_08]
    set_three[BIT_CCP_FOUR]   = ccp_set[2];
    set_three[BIT_CCP_FIVE]   = ccp_set[3];
    nxt_flags_two = set_two | (flags_two_ff &
                    ~((wr_en && addr_ff == ADDR_FLAGS_TWO) ? wbyte : 8'h00));
    nxt_flags_three = (set_three | (flags_three_ff &
                      ~((wr_en && addr_ff == ADDR_FLAGS_THREE) ? wbyte : 8'h00)))
                      & ~FLAGS_THREE_HW_MASK;
    nxt_flags_three[BIT_RX_TWO] = rx_two_full && !rx_two_buf_read;   // [RULE_11]
    nxt_flags_three[BIT_TX_TWO] = tx_two_empty && !tx_two_buf_write; // [RULE_12]
    nxt_enables_one = (wr_en && addr_ff == ADDR_ENABLES_ONE) ? wbyte : enables_one_ff;
    nxt_enables_two = (wr_en && addr_ff == ADDR_ENABLES_TWO) ? wbyte : enables_two_ff;
    nxt_enables_three = (wr_en && addr_ff == ADDR_ENABLES_THREE) ? wbyte : enables_three_ff;
    nxt_control = (wr_en && addr_ff == ADDR_CONTROL) ? wbyte[1:0] : control_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_two_ff     <= RESET_BYTE;
      flags_three_ff   <= RESET_BYTE;
      enables_one_ff   <= RESET_BYTE;
      enables_two_ff   <= RESET_BYTE;
      enables_three_ff <= RESET_BYTE;
      control_ff       <= 2'b00;
    end else begin
      flags_two_ff     <= nxt_flags_two;
      flags_three_ff   <= nxt_flags_three;
      enables_one_ff   <= nxt_enables_one;
      enables_two_ff   <= nxt_enables_two;
      enables_three_ff <= nxt_enables_three;
      control_ff       <= nxt_control;
    end
  end

  // request: flag and enable, then priority split and global gating
  always_comb begin
    pend = {flags_three_ff & enables_three_ff,
            flags_two_ff & enables_two_ff,
            flags_one_in & enables_one_ff}; // [RULE_15] [RULE_19]
    any_high = |(pend & prio_high_in);
    any_low  = |(pend & ~prio_high_in);
    nxt_irq_high = control_ff[CTRL_PRIO] && any_high;
    nxt_irq_low  = control_ff[CTRL_PRIO] && control_ff[CTRL_GLOBAL] && any_low; // [RULE_17]
    nxt_periph_irq = control_ff[CTRL_PRIO] ? (nxt_irq_high || nxt_irq_low)
                   : (control_ff[CTRL_GLOBAL] && (|pend)); // [RULE_14]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_irq_ff <= 1'b0;
      irq_high_ff   <= 1'b0;
      irq_low_ff    <= 1'b0;
    end else begin
      periph_irq_ff <= nxt_periph_irq;
      irq_high_ff   <= nxt_irq_high;
      irq_low_ff    <= nxt_irq_low;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_addr_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_one_wait;
    !hreadyout_ff ##1 hreadyout_ff;
  endsequence

  property p_bus_wait;
    s_addr_taken |=> s_one_wait;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait");

  property p_osc_set;
    osc_fail_evt && enables_two_ff == 8'h00 |=> flags_two_ff[BIT_OSC_FAIL];
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("osc fail flag not set"); // [RULE_01] [RULE_16]

  property p_cmp_set;
    cmp_two_evt |=> flags_two_ff[BIT_CMP_TWO];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator flag not set"); // [RULE_02]

  property p_usb_set;
    usb_req_evt |=> flags_two_ff[BIT_USB] [*1];
  endproperty
  a_usb_set: assert property (p_usb_set) else $error("usb flag not set"); // [RULE_03]

  property p_coll_hold;
    flags_three_ff[BIT_COLL_TWO] && !wr_en |=> flags_three_ff[BIT_COLL_TWO];
  endproperty
  a_coll_hold: assert property (p_coll_hold) else $error("collision flag lost"); // [RULE_04]

  property p_lowv_clear;
    wr_en && addr_ff == ADDR_FLAGS_TWO && wbyte[BIT_LOW_VOLT] && !low_volt_evt
      |=> !flags_two_ff[BIT_LOW_VOLT];
  endproperty
  a_lowv_clear: assert property (p_lowv_clear) else $error("low voltage flag not cleared"); // [RULE_05]

  property p_tmr3_set;
    tmr3_ovf_evt |=> flags_two_ff[BIT_TMR3_OVF];
  endproperty
  a_tmr3_set: assert property (p_tmr3_set) else $error("timer three flag not set"); // [RULE_06]

  property p_ccp_set;
    ccp_capture_evt[1] && !ccp_pwm_mode[1] |=> flags_three_ff[BIT_CCP_THREE];
  endproperty
  a_ccp_set: assert property (p_ccp_set) else $error("capture flag not set"); // [RULE_07]

  property p_ccp_match;
    ccp_match_evt[0] && !ccp_pwm_mode[0] |=> flags_two_ff[BIT_CCP_TWO];
  endproperty
  a_ccp_match: assert property (p_ccp_match) else $error("compare flag not set"); // [RULE_08]

  property p_ccp_pwm;
    ccp_pwm_mode[3] && !flags_three_ff[BIT_CCP_FIVE] |=> !flags_three_ff[BIT_CCP_FIVE];
  endproperty
  a_ccp_pwm: assert property (p_ccp_pwm) else $error("pwm unit set its flag"); // [RULE_09]

  property p_ssp_set;
    ssp_two_done_evt |=> flags_three_ff[BIT_SSP_TWO];
  endproperty
  a_ssp_set: assert property (p_ssp_set) else $error("sync serial flag not set"); // [RULE_10]

  property p_rx_level;
    rx_two_full && !rx_two_buf_read |=> flags_three_ff[BIT_RX_TWO];
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive flag wrong"); // [RULE_11]

  property p_tx_clear;
    tx_two_buf_write |=> !flags_three_ff[BIT_TX_TWO];
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit flag not cleared"); // [RULE_12]

  property p_tmr4_set;
    tmr4_match_evt |=> flags_three_ff[BIT_TMR4_MATCH];
  endproperty
  a_tmr4_set: assert property (p_tmr4_set) else $error("timer four flag not set"); // [RULE_13]

  property p_global_block;
    !control_ff[CTRL_PRIO] && !control_ff[CTRL_GLOBAL] |=> !periph_irq_ff;
  endproperty
  a_global_block: assert property (p_global_block) else $error("irq passed without global"); // [RULE_14]

  property p_enable_one;
    !control_ff[CTRL_PRIO] && control_ff[CTRL_GLOBAL] && |(flags_one_in & enables_one_ff)
      |=> periph_irq_ff;
  endproperty
  a_enable_one: assert property (p_enable_one) else $error("enabled source not raised"); // [RULE_15] [RULE_19]

  property p_low_block;
    control_ff[CTRL_PRIO] && !control_ff[CTRL_GLOBAL] |=> !irq_low_ff;
  endproperty
  a_low_block: assert property (p_low_block) else $error("low priority irq not blocked"); // [RULE_17]

  property p_cmp_one_set;
    cmp_one_evt |=> flags_two_ff[BIT_CMP_ONE];
  endproperty
  a_cmp_one_set: assert property (p_cmp_one_set) else $error("comparator one flag not set"); // [RULE_02]

  property p_coll_one_set;
    coll_one_evt |=> flags_two_ff[BIT_COLL_ONE];
  endproperty
  a_coll_one_set: assert property (p_coll_one_set) else $error("collision one flag not set"); // [RULE_04]

  property p_coll_two_set;
    coll_two_evt |=> flags_three_ff[BIT_COLL_TWO];
  endproperty
  a_coll_two_set: assert property (p_coll_two_set) else $error("collision two flag not set"); // [RULE_04]

  property p_lowv_set;
    low_volt_evt |=> flags_two_ff[BIT_LOW_VOLT];
  endproperty
  a_lowv_set: assert property (p_lowv_set) else $error("low voltage flag not set"); // [RULE_05]

  property p_osc_hold;
    flags_two_ff[BIT_OSC_FAIL] && !(wr_en && addr_ff == ADDR_FLAGS_TWO)
      |=> flags_two_ff[BIT_OSC_FAIL];
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("osc fail flag lost"); // [RULE_01]

  property p_ccp_five_set;
    ccp_capture_evt[3] && !ccp_pwm_mode[3] |=> flags_three_ff[BIT_CCP_FIVE];
  endproperty
  a_ccp_five_set: assert property (p_ccp_five_set) else $error("unit five flag not set"); // [RULE_07]

  property p_ccp_four_match;
    ccp_match_evt[2] && !ccp_pwm_mode[2] |=> flags_three_ff[BIT_CCP_FOUR];
  endproperty
  a_ccp_four_match: assert property (p_ccp_four_match) else $error("unit four flag not set"); // [RULE_08]

  property p_ccp_pwm_two;
    ccp_pwm_mode[0] && !flags_two_ff[BIT_CCP_TWO] |=> !flags_two_ff[BIT_CCP_TWO];
  endproperty
  a_ccp_pwm_two: assert property (p_ccp_pwm_two) else $error("pwm unit two set its flag"); // [RULE_09]

  property p_rx_clear;
    rx_two_buf_read |=> !flags_three_ff[BIT_RX_TWO];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag not cleared"); // [RULE_11]

  property p_tx_level;
    tx_two_empty && !tx_two_buf_write |=> flags_three_ff[BIT_TX_TWO];
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("transmit flag not high"); // [RULE_12]

  property p_high_pass;
    control_ff[CTRL_PRIO] && any_high |=> irq_high_ff;
  endproperty
  a_high_pass: assert property (p_high_pass) else $error("high priority irq not raised"); // [RULE_19]

  property p_low_pass;
    control_ff[CTRL_PRIO] && control_ff[CTRL_GLOBAL] && any_low |=> irq_low_ff;
  endproperty
  a_low_pass: assert property (p_low_pass) else $error("low priority irq not raised"); // [RULE_17]

endmodule : pif_top
`default_nettype wire

// ---- testbench/pif_periph_model.sv ----
// pif_periph_model: far side of the flag block; replays event requests as
// pulses one cycle later, each as long as its request, and keeps the serial-two buffer levels.
// assumes requests change just after a rising hclk edge.
`timescale 1ns/10ps
`default_nettype none
module pif_periph_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [17:0] ev_req,
  input  wire logic        rx_fill,
  input  wire logic        tx_drain,
  input  wire logic        rx_two_buf_read,
  input  wire logic        tx_two_buf_write,
  output logic      [17:0] ev_pulse,
  output logic             rx_two_full,
  output logic             tx_two_empty
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_pulse     <= 18'h0;
      rx_two_full  <= 1'b0;
      tx_two_empty <= 1'b1;
    end else begin
      ev_pulse <= ev_req;
      // full from arrival until software reads the buffer
      if (rx_fill)
        rx_two_full <= 1'b1;
      else if (rx_two_buf_read)
        rx_two_full <= 1'b0;
      if (tx_two_buf_write)
        tx_two_empty <= 1'b0;
      else if (tx_drain)
        tx_two_empty <= 1'b1;
    end
  end
endmodule : pif_periph_model
`default_nettype wire

// ---- testbench/peripheral_interrupt_flags_enables_tb.sv ----
// peripheral_interrupt_flags_enables_tb: random and corner stimulus for pif_top
// over AHB-Lite, with the peripheral model on the event side.
// assumes the single slave's hreadyout is the bus hready.
`timescale 1ns/10ps
`default_nettype none
module peripheral_interrupt_flags_enables_tb;
  import pif_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, periph_irq, irq_high, irq_low;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [17:0] ev_req, ev_pulse, v;
  logic [3:0]  pwm;
  logic        rx_fill, tx_drain, rx_rd, tx_wr, rx_full, tx_empty;
  logic [7:0]  f1, e1, ex2, ex3, m;
  logic [23:0] prio;
  int          fails, check_count;

  pif_top pif_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_fail_evt(ev_pulse[0]),
    .cmp_two_evt(ev_pulse[1]), .cmp_one_evt(ev_pulse[2]), .usb_req_evt(ev_pulse[3]),
    .coll_one_evt(ev_pulse[4]), .low_volt_evt(ev_pulse[5]), .tmr3_ovf_evt(ev_pulse[6]),
    .tmr4_match_evt(ev_pulse[7]), .ssp_two_done_evt(ev_pulse[8]), .coll_two_evt(ev_pulse[9]),
    .ccp_capture_evt(ev_pulse[13:10]), .ccp_match_evt(ev_pulse[17:14]), .ccp_pwm_mode(pwm),
    .rx_two_full(rx_full), .rx_two_buf_read(rx_rd), .tx_two_empty(tx_empty),
    .tx_two_buf_write(tx_wr), .flags_one_in(f1), .prio_high_in(prio),
    .periph_irq(periph_irq), .irq_high(irq_high), .irq_low(irq_low));
  pif_periph_model pif_periph_model_i (.hclk(hclk), .hresetn(hresetn), .ev_req(ev_req),
    .rx_fill(rx_fill), .tx_drain(tx_drain), .rx_two_buf_read(rx_rd),
    .tx_two_buf_write(tx_wr), .ev_pulse(ev_pulse), .rx_two_full(rx_full),
    .tx_two_empty(tx_empty));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ_BIT1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    // ready is looked at half a cycle before the edge, where it has settled
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    rdat = hrdata;
    @(posedge hclk);
  endtask : bus

  task automatic fire(input logic [17:0] e, input logic [3:0] p);
    @(posedge hclk);
    ev_req <= e;
    pwm    <= p;
    @(posedge hclk);
    ev_req <= 18'h0;
    repeat (2) @(posedge hclk);
  endtask : fire

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("periph_irq", {31'h0, periph_irq}, {31'h0, exp});
    @(posedge hclk);
  endtask : irqchk

  function automatic logic [15:0] ev_bits(input logic [17:0] e, input logic [3:0] p);
    logic [3:0] c;
    c = (e[13:10] | e[17:14]) & ~p;
    return {e[8], e[9], 2'b00, e[7], c[3:1], e[0], e[1], e[2], e[3], e[4], e[5], e[6], c[0]};
  endfunction : ev_bits

  initial begin
    #(5 * 20000);
    fails++;
    conclude();
  end

  initial begin
    {hsel, hwrite, rx_fill, tx_drain, rx_rd, tx_wr} = 6'h0;
    {haddr, hwdata, htrans, ev_req, pwm, f1, prio} = '0;
    {fails, check_count, ex2, ex3} = '0;
    hresetn = 1'b0;
    void'($urandom(32'ha5af));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0, rd);
      chk("reset_value", rd, (i == 1) ? 32'h10 : 32'h0);
    end
    bus(1'b1, 8'h18, 32'hffffffff, rd);
    bus(1'b0, 8'h18, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h1, rd);
    for (int k = 0; k < 40; k++) begin
      v = (k < 18) ? (18'h1 << k) : 18'($urandom);
      fire(v, (k < 18) ? 4'h0 : 4'($urandom));
      {ex3, ex2} = {ex3, ex2} | ev_bits(v, pwm);
      bus(1'b0, ADDR_FLAGS_TWO, 32'h0, rd);
      chk("flags_two", rd, {24'h0, ex2});
      bus(1'b0, ADDR_FLAGS_THREE, 32'h0, rd);
      chk("flags_three", rd, {24'h0, ex3 | 8'h10});
      chk("irq_disabled", {31'h0, periph_irq}, 32'h0);
      m = 8'($urandom);
      bus(1'b1, ADDR_FLAGS_TWO, {24'h0, m}, rd);
      ex2 = ex2 & ~m;
      m = 8'($urandom);
      bus(1'b1, ADDR_FLAGS_THREE, {24'h0, m}, rd);
      ex3 = ex3 & ~(m & 8'hcf);
    end
    // flags cleared before any enable is set
    bus(1'b1, ADDR_FLAGS_TWO, 32'hff, rd);
    bus(1'b1, ADDR_FLAGS_THREE, 32'hff, rd);
    bus(1'b1, ADDR_ENABLES_TWO, 32'h80, rd);
    fire(18'h1, 4'h0);
    irqchk(1'b1);
    bus(1'b1, ADDR_CONTROL, 32'h0, rd);
    irqchk(1'b0);
    bus(1'b1, ADDR_CONTROL, 32'h3, rd);
    irqchk(1'b1);
    chk("irq_low", {31'h0, irq_low}, 32'h1);
    bus(1'b1, ADDR_CONTROL, 32'h2, rd);
    irqchk(1'b0);
    prio <= 24'h008000;
    irqchk(1'b1);
    chk("irq_high", {31'h0, irq_high}, 32'h1);
    prio <= 24'h0;
    bus(1'b1, ADDR_CONTROL, 32'h1, rd);
    bus(1'b1, ADDR_ENABLES_TWO, 32'h0, rd);
    irqchk(1'b0);
    bus(1'b1, ADDR_ENABLES_TWO, 32'h80, rd);
    irqchk(1'b1);
    bus(1'b1, ADDR_FLAGS_TWO, 32'h80, rd);
    irqchk(1'b0);
    bus(1'b1, ADDR_ENABLES_TWO, 32'h0, rd);
    for (int k = 0; k < 20; k++) begin
      f1 <= 8'($urandom);
      e1 = (k == 0) ? 8'h0 : 8'($urandom);
      bus(1'b1, ADDR_ENABLES_ONE, {24'h0, e1}, rd);
      bus(1'b0, ADDR_ENABLES_ONE, 32'h0, rd);
      chk("enables_one", rd, {24'h0, e1});
      irqchk(|(f1 & e1));
    end
    // third enable register gates the transmit-empty level flag
    bus(1'b1, ADDR_ENABLES_ONE, 32'h0, rd);
    bus(1'b1, ADDR_ENABLES_THREE, 32'h10, rd);
    bus(1'b0, ADDR_ENABLES_THREE, 32'h0, rd);
    chk("enables_three", rd, 32'h10);
    irqchk(1'b1);
    bus(1'b1, ADDR_ENABLES_THREE, 32'h0, rd);
    irqchk(1'b0);
    @(posedge hclk) rx_fill <= 1'b1;
    @(posedge hclk) rx_fill <= 1'b0;
    bus(1'b1, ADDR_FLAGS_THREE, 32'h30, rd);
    bus(1'b0, ADDR_FLAGS_THREE, 32'h0, rd);
    chk("rx_full", rd, 32'h30);
    @(posedge hclk) rx_rd <= 1'b1;
    @(posedge hclk) rx_rd <= 1'b0;
    bus(1'b0, ADDR_FLAGS_THREE, 32'h0, rd);
    chk("rx_read", rd, 32'h10);
    @(posedge hclk) tx_wr <= 1'b1;
    @(posedge hclk) tx_wr <= 1'b0;
    bus(1'b0, ADDR_FLAGS_THREE, 32'h0, rd);
    chk("tx_write", rd, 32'h0);
    @(posedge hclk) tx_drain <= 1'b1;
    @(posedge hclk) tx_drain <= 1'b0;
    bus(1'b0, ADDR_FLAGS_THREE, 32'h0, rd);
    chk("tx_empty", rd, 32'h10);
    conclude();
  end
endmodule : peripheral_interrupt_flags_enables_tb
`default_nettype wire
